// file: src/monitor_sampling_scheduler_defines.svh
// Constants of the monitor sampling scheduler: offsets, fields, resets,
// and timing. Assumes inclusion by bare name from the design file.
`ifndef MONITOR_SAMPLING_SCHEDULER_DEFINES_SVH
`define MONITOR_SAMPLING_SCHEDULER_DEFINES_SVH

// Register indices; the APB byte address is four times the index.
`define MON_PERIOD_CFG_IDX   16'h0480
`define MON_RUN_CTRL_IDX     16'h0481
`define MON_PERIOD_CFG_ADDR  16'h1200
`define MON_RUN_CTRL_ADDR    16'h1204

// Field positions.
`define MON_PERIOD_MSB       3
`define MON_PERIOD_LSB       0
`define MON_PERIODIC_BIT     1
`define MON_START_BIT        0
`define MON_RSVD_MSB         15
`define MON_RSVD_LSB         2

// Reset values.
`define MON_PERIOD_RST       4'h2
`define MON_PERIODIC_RST     1'h1
`define MON_START_RST        1'h0
`define MON_RSVD_RST         14'h0028

// Timing: one period step in ms, clock rate in Hz.
`define MON_STEP_MS          16
`define MON_CLK_HZ           100000000

`endif

// file: src/monitor_sampling_scheduler_pkg.sv
// Types of the monitor sampling scheduler.
// Assumes the defines header supplies every number.
`default_nettype none

package monitor_sampling_scheduler_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_WAIT   = 3'b100
    } schedState_t;

    typedef struct packed {
        logic [13:0] reserved;
        logic        periodic;
        logic [3:0]  period;
    } monitorCfg_t;

endpackage

`default_nettype wire

// file: src/monitor_sampling_scheduler.sv
// Scheduler that launches temperature and supply monitor runs, once or
// periodically, behind two registers on an APB slave.
// Assumes the sensor front end pulses measureDone on mclk after each run.
//
// Operation
// - Periodic mode uses period field bits 3:0; field resets to 0010.
// - Selectable sampling cycle spans 16 ms up to 240 ms.
// - Periodic bit at position 1, reset set, repeats monitor activations.
// - Periodic bit cleared gives one single monitoring run per trigger.
// - Writing one to start bit 0 launches a run; bit self-clears.
// - Periodic interval comes from bits 3:0 of register 0x480.
//
// Register map: every register is one aligned word with its data in the
// low 16 bits, and the bits above read as zero.
// The period register at index 0x480 holds the period code in bits 3:0;
// its other bits read as zero and ignore writes.
// The run register at index 0x481 holds the start bit in bit 0, the
// periodic-mode bit in bit 1 and plain storage in bits 15:2.
// The byte address of each register is four times its index.
// An unmapped address is refused with an error and reads as zero.
//
// Timing: the slave answers with no wait states. Read data and the error
// flag are captured at the end of the setup cycle and stand until the
// next setup, so they are valid throughout the access phase.
// A start write sets a pending flag at its access edge; the launch pulse
// follows at the next edge when the scheduler is free.
// A start written during a run stays pending and launches after done.
// In periodic mode the next launch comes period code times one step after
// the done of the previous run, so run time is not part of the interval.
// A period code of zero would never expire; it is treated as one step so
// the scheduler cannot lock up when software breaks the rule.
// Clearing periodic mode while a run is busy lets the run finish first.
// One step is STEP_CYCLES clocks; the default gives 16 ms at 100 MHz, and
// a bench may shorten it to keep runs brief.
`include "monitor_sampling_scheduler_defines.svh"
`default_nettype none

module monitor_sampling_scheduler
    import monitor_sampling_scheduler_pkg::*;
#(
    parameter int unsigned STEP_CYCLES =
        `MON_STEP_MS * (`MON_CLK_HZ / 1000)
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             measureStart,
    input  wire logic        measureDone,
    output logic             monitorActive
);

    logic        rstSync1;
    logic        rstSync2;
    monitorCfg_t cfg;
    logic        startPending;
    schedState_t state;
    schedState_t next_state;
    logic [31:0] stepCount;
    logic [3:0]  stepsDone;

    // Reset is released through two flip-flops.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    wire logic resetN = rstSync2;

    // APB decode. One wait-free access phase; read data is latched in setup.
    wire logic setupPhase = psel && !penable;
    wire logic accessPhase = psel && penable;
    wire logic hitPeriod = (paddr == `MON_PERIOD_CFG_ADDR);
    wire logic hitRun = (paddr == `MON_RUN_CTRL_ADDR);
    wire logic unmapped = !(hitPeriod || hitRun);
    wire logic wrPeriod = accessPhase && pwrite && hitPeriod;
    wire logic wrRun = accessPhase && pwrite && hitRun;
    wire logic startWrite = wrRun && pwdata[`MON_START_BIT];

    wire logic [31:0] periodWord = {28'h0000000, cfg.period};
    wire logic [31:0] runWord =
        {16'h0000, cfg.reserved, cfg.periodic, startPending};
    wire logic [31:0] readWord =
        hitPeriod ? periodWord : (hitRun ? runWord : 32'h00000000);

    assign pready = accessPhase;

    // Zero would never expire; it is treated as one step so the block
    // cannot lock up when software breaks the programming limit.
    wire logic [3:0] periodSteps =
        (cfg.period == 4'h0) ? 4'h1 : cfg.period;

    // One step is STEP_CYCLES clocks, 16 ms by default; a period is periodSteps whole steps.
    wire logic stepTick = (stepCount == 32'(STEP_CYCLES - 1));
    wire logic periodExpire =
        stepTick && (stepsDone == 4'(periodSteps - 4'h1));

    wire logic inWait = (state == ST_WAIT);
    wire logic inIdle = (state == ST_IDLE);
    wire logic inSample = (state == ST_SAMPLE);

    // A pending start is taken from idle in either mode. From the wait
    // state only periodic mode relaunches, on a new start or on expiry.
    wire logic idleLaunch = inIdle && startPending;
    wire logic waitTrigger = startPending || periodExpire;
    wire logic waitLaunch =
        inWait && cfg.periodic && waitTrigger;
    wire logic launch = idleLaunch || waitLaunch;

    // The end of a run decides between waiting and stopping. Clearing the
    // periodic bit mid-run lets the run finish and then drops to idle.
    wire logic runDone = inSample && measureDone;
    wire logic runToWait = runDone && cfg.periodic;
    wire logic runToIdle = runDone && !cfg.periodic;
    wire logic waitToIdle = inWait && !cfg.periodic;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (idleLaunch) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (runToWait) begin
                    next_state = ST_WAIT;
                end else if (runToIdle) begin
                    // Single-run mode stops after each run.
                    next_state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (waitLaunch) begin
                    next_state = ST_SAMPLE;
                end else if (waitToIdle) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Stored fields live in their own flops; cfg only bundles them.
    localparam logic [13:0] RSVD_RST = `MON_RSVD_RST;
    logic [3:0]  periodField;
    logic        periodicBit;
    logic [13:0] rsvdStore;

    assign cfg = {rsvdStore, periodicBit, periodField};

    // Next values of the stored fields. Only an access to a mapped
    // address changes them; a refused write leaves every field alone.
    wire logic [3:0] next_period =
        wrPeriod ? pwdata[`MON_PERIOD_MSB:`MON_PERIOD_LSB] : periodField;
    wire logic next_periodic =
        wrRun ? pwdata[`MON_PERIODIC_BIT] : periodicBit;
    wire logic [13:0] next_reserved =
        wrRun ? pwdata[`MON_RSVD_MSB:`MON_RSVD_LSB] : rsvdStore;

    // A start written in the cycle that consumes the old one stays set.
    wire logic next_startPending =
        startWrite ? 1'b1 : (launch ? 1'b0 : startPending);

    // Read data and error are captured in the setup cycle and stand
    // through the access phase until the next setup.
    wire logic [31:0] next_prdata = setupPhase ? readWord : prdata;
    wire logic next_pslverr = setupPhase ? unmapped : pslverr;

    // Interval is timed from the end of one run to the next launch; the
    // counters rest at zero outside the wait state.
    wire logic clearCount = !inWait || launch;
    wire logic [31:0] stepCountInc = stepCount + 32'h00000001;
    wire logic [3:0] stepsDoneInc = stepsDone + 4'h1;
    wire logic [31:0] next_stepCount =
        (clearCount || stepTick) ? 32'h00000000 : stepCountInc;
    wire logic [3:0] next_stepsDone =
        clearCount ? 4'h0 : (stepTick ? stepsDoneInc : stepsDone);

    // Launch pulse and activity flag are registered so they never glitch.
    wire logic next_measureStart = launch;
    wire logic next_monitorActive = (next_state == ST_SAMPLE);

    // Period code of the periodic mode.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            periodField <= `MON_PERIOD_RST;
        end else begin
            periodField <= next_period;
        end
    end

    // Periodic-mode bit, set out of reset.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            periodicBit <= `MON_PERIODIC_RST;
        end else begin
            periodicBit <= next_periodic;
        end
    end

    // Each storage bit of the run register has its own reset value.
    for (genvar i = 0; i < 14; i++) begin : g_rsvd
        always_ff @(posedge mclk or negedge resetN) begin
            if (!resetN) begin
                rsvdStore[i] <= RSVD_RST[i];
            end else begin
                rsvdStore[i] <= next_reserved[i];
            end
        end
    end

    // Pending start, read back as the start bit until it is consumed.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            startPending <= `MON_START_RST;
        end else begin
            startPending <= next_startPending;
        end
    end

    // Read data register of the slave.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // Error flag of the slave.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= next_pslverr;
        end
    end

    // Clock count within one step.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            stepCount <= 32'h00000000;
        end else begin
            stepCount <= next_stepCount;
        end
    end

    // Whole steps counted since the last run ended.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            stepsDone <= 4'h0;
        end else begin
            stepsDone <= next_stepsDone;
        end
    end

    // Scheduler state.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // One-cycle launch pulse towards the sensor front end.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            measureStart <= 1'b0;
        end else begin
            measureStart <= next_measureStart;
        end
    end

    // High from the launch until the run reports done.
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            monitorActive <= 1'b0;
        end else begin
            monitorActive <= next_monitorActive;
        end
    end

endmodule // monitor_sampling_scheduler

`default_nettype wire

// file: bench/monitor_sampling_scheduler_monitor.sv
// Checker of the scheduler's APB answers and launch handshake.
// Assumes a bind onto the scheduler top; sees only its ports.
`default_nettype none
module monitor_sampling_scheduler_monitor #(
    parameter int unsigned STEP_CYCLES = 10
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        measureStart,
    input wire logic        measureDone,
    input wire logic        monitorActive
);
    wire logic acc = psel && penable;
    wire logic cfgHit = paddr == 16'h1200;
    wire logic runHit = paddr == 16'h1204;
    // A start written during a run waits, so only an idle launch is timed.
    wire logic idleStart = acc && pwrite && runHit && pwdata[0]
        && !monitorActive && !measureStart;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_start_launch: assert property (idleStart |-> ##2 measureStart)
        else $error("start write did not launch a run");
    a_start_pulse: assert property (measureStart |=> !measureStart)
        else $error("launch pulse longer than one cycle");
    a_active_rise: assert property ($rose(monitorActive) |-> measureStart)
        else $error("run began without a launch");
    a_start_idle: assert property (measureStart |-> !$past(monitorActive))
        else $error("launch while a run was active");
    a_done_ends: assert property (measureDone && monitorActive |=>
        !monitorActive) else $error("run outlived its done");
    a_run_holds: assert property (monitorActive && !measureDone |=>
        monitorActive) else $error("run ended without done");
    a_cfg_read: assert property (acc && !pwrite && cfgHit |->
        prdata[31:4] == 28'h0 && !pslverr) else $error("bad period read");
    a_bad_addr: assert property (acc && !cfgHit && !runHit |->
        pslverr && prdata == 32'h0) else $error("unmapped not refused");
endmodule // monitor_sampling_scheduler_monitor

bind monitor_sampling_scheduler monitor_sampling_scheduler_monitor
    #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.mclk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .measureStart,
    .measureDone, .monitorActive);
`default_nettype wire

// file: bench/monitor_sampling_scheduler_tb.sv
// Directed bench for the scheduler: APB tasks and launch timing tests.
// Assumes the design, its package and the checker are compiled first.
`default_nettype none
module monitor_sampling_scheduler_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int S = 10;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        measureStart, measureDone, monitorActive, perr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int          err_total, checks, n;

    monitor_sampling_scheduler #(.STEP_CYCLES(S)) i_dut (.mclk, .rst_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .measureStart, .measureDone, .monitorActive);

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic hang;
        err_total++;
        end_sim();
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic apb(input logic [15:0] a, input logic [31:0] d,
                       input logic w);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        paddr <= a;
        pwdata <= d;
        pwrite <= w;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) hang();
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // The gap is timed from done, so counting starts at the done edge.
    task automatic waitStart(input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge mclk);
            #1;
            if (measureStart === 1'b1) break;
        end
        if (n > lim) hang();
    endtask

    task automatic pulseDone;
        @(posedge mclk);
        measureDone <= 1'b1;
        @(posedge mclk);
        measureDone <= 1'b0;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        {rst_n, psel, penable, pwrite, measureDone} = 5'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        err_total = 0;
        checks = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(16'h1200, 32'h0, 1'b0);
        chk(rdat, 32'h2);
        apb(16'h1204, 32'h0, 1'b0);
        chk(rdat, 32'ha2);
        apb(16'h1208, 32'h0, 1'b0);
        chk(perr, 1'b1);
        apb(16'h1200, 32'hffff, 1'b1);
        apb(16'h1200, 32'h0, 1'b0);
        chk(rdat, 32'hf);
        $display("test registers done");
        for (int p = 1; p < 16; p++) begin
            apb(16'h1200, p, 1'b1);
            apb(16'h1204, 32'ha3, 1'b1);
            waitStart(40);
            pulseDone();
            waitStart(4000);
            chk(n, p * S);
            pulseDone();
            apb(16'h1204, 32'ha0, 1'b1);
        end
        $display("test periods done");
        apb(16'h1204, 32'ha1, 1'b1);
        waitStart(40);
        chk(monitorActive, 1'b1);
        apb(16'h1204, 32'h0, 1'b0);
        chk(rdat, 32'ha0);
        pulseDone();
        repeat (300) begin
            @(posedge mclk);
            #1;
            chk(measureStart, 1'b0);
            chk(monitorActive, 1'b0);
        end
        $display("test single done");
        end_sim();
    end
endmodule // monitor_sampling_scheduler_tb
`default_nettype wire
